// *** dv/fsp_host_model.sv ***
// fsp_host_model: host-side command source for the status block; it
// issues commands, polls busy and notes each expected answer in exp_q.
// assumes the bench pops exp_q whenever the block answers a command.
`timescale 1ns/10ps
module fsp_host_model
    import fsp_pkg::*;
(
    // clock
    input wire logic clk,
    // command port
    output logic cmd_valid,
    output fsp_pkg::fsp_cmd_req_t cmd_req,
    // status seen by the host
    input wire logic [7:0] status_byte
);
    logic [1:0] exp_q[$];

    initial
    begin
        cmd_valid = 1'b0;
        cmd_req = '0;
    end

    // gap idles make the host slow on request; data is inverted between
    // commands so a stale operand can never pass for a live one
    task automatic send(input fsp_cmd_t op, input logic [7:0] d,
        input logic [9:0] b, input logic [1:0] e, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_req <= '{op: op, wdata: d, blk_lo: b, blk_hi: b};
        exp_q.push_back(e);
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_req.wdata <= ~d;
    endtask

    task automatic we_then(input fsp_cmd_t op, input logic [7:0] d,
        input logic [9:0] b, input logic [1:0] e);
        send(FSP_CMD_WRITE_ENABLE, 8'h00, 10'h000, 2'b10, 0);
        send(op, d, b, e, 0);
    endtask

    // polling costs a status read per try, bounded so a stuck busy ends
    task automatic poll_idle(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++)
        begin
            send(FSP_CMD_READ_STATUS, 8'h00, 10'h000, 2'b10, 0);
            @(posedge clk);
            ok = (status_byte[0] === 1'b0);
        end
    endtask
endmodule

// *** dv/testbench.sv ***
// testbench: drives the status block through its command port and pins
// and checks answers, status byte, ready flag and reset output.
// assumes fsp_host_model as command source; op length shortened to 12.
`timescale 1ns/10ps
module testbench;
    import fsp_pkg::*;
    localparam logic [1:0] ACC = 2'b10;
    localparam logic [1:0] IGN = 2'b01;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic write_protect_n = 1'b1;
    logic reset_pin_n = 1'b1;
    logic init_done = 1'b0;
    logic init_fail = 1'b0;
    logic octal_double_rate_mode = 1'b0;
    logic protect_invert_bit = 1'b0;
    logic cmd_valid;
    fsp_cmd_req_t cmd_req;
    logic cmd_accepted;
    logic cmd_ignored;
    logic reset_output_pin_o;
    logic reset_output_pin_oe_n;
    logic [7:0] status_byte;
    logic ready_flag;
    logic op_done;
    logic op_abort;
    int mismatches = 0;
    int total_checks = 0;
    int dones = 0;
    int seed = 32'h8F3E;
    logic [7:0] rnd;
    bit ok;
    fsp_cmd_t ops[7] = '{FSP_CMD_PAGE_PROGRAM, FSP_CMD_SECTOR_ERASE,
        FSP_CMD_BLOCK_ERASE, FSP_CMD_CHIP_ERASE, FSP_CMD_NONVOLATILE_CONFIG_REG_WRITE,
        FSP_CMD_SECREG_PE, FSP_CMD_PATREG_PE};

    always #12.5 clk = ~clk;

    fsp_status_reg #(.OP_CYCLES(12)) fsp_status_reg_inst (.clk(clk),
        .sys_rst(sys_rst), .write_protect_n(write_protect_n),
        .reset_pin_n(reset_pin_n), .reset_output_pin_o(reset_output_pin_o),
        .reset_output_pin_oe_n(reset_output_pin_oe_n),
        .init_done(init_done), .init_fail(init_fail),
        .octal_double_rate_mode(octal_double_rate_mode),
        .protect_invert_bit(protect_invert_bit), .cmd_valid(cmd_valid),
        .cmd_req(cmd_req), .cmd_accepted(cmd_accepted),
        .cmd_ignored(cmd_ignored), .status_byte(status_byte),
        .ready_flag(ready_flag), .op_done(op_done), .op_abort(op_abort));

    fsp_host_model fsp_host_model_inst (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_req(cmd_req), .status_byte(status_byte));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // oldest noted answer against each answer pulse
    always @(posedge clk)
        if (cmd_accepted === 1'b1 || cmd_ignored === 1'b1)
        begin
            if (fsp_host_model_inst.exp_q.size() == 0)
                chk({cmd_accepted, cmd_ignored}, 16'h0000);
            else
                chk({cmd_accepted, cmd_ignored},
                    fsp_host_model_inst.exp_q.pop_front());
        end

    // every normal end of an internal operation is counted
    always @(posedge clk)
        if (op_done === 1'b1)
            dones++;

    task automatic s(input fsp_cmd_t op, input logic [1:0] e);
        fsp_host_model_inst.send(op, 8'h00, 10'h000, e, $random(seed) & 1);
    endtask

    task automatic run(input bit we, input fsp_cmd_t op, input logic [7:0] d,
        input logic [9:0] b, input logic [7:0] fin);
        int d0;
        d0 = dones;
        if (we)
            fsp_host_model_inst.we_then(op, d, b, ACC);
        else
            fsp_host_model_inst.send(op, d, b, ACC, 0);
        @(posedge clk);
        chk({ready_flag, status_byte[1:0]}, 16'h0003);
        fsp_host_model_inst.poll_idle(ok);
        chk({ok, ready_flag, status_byte}, {8'h03, fin});
        // one more edge so the done counter has seen the last pulse
        @(posedge clk);
        chk(16'(dones - d0), 16'h0001);
    endtask

    task automatic wait_abort;
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < 8 && !seen; i++)
        begin
            @(posedge clk);
            seen = (op_abort === 1'b1);
        end
        chk(seen, 16'h0001);
    endtask

    task automatic init_pulse(input logic f);
        @(posedge clk);
        init_done <= 1'b1;
        init_fail <= f;
        @(posedge clk);
        init_done <= 1'b0;
        @(posedge clk);
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        chk({reset_output_pin_oe_n, ready_flag, status_byte}, 16'h0001);
        s(FSP_CMD_READ_STATUS, ACC);
        s(FSP_CMD_WRITE_ENABLE, IGN);
        init_pulse(1'b0);
        chk({reset_output_pin_o, reset_output_pin_oe_n, ready_flag,
            status_byte}, 16'h0300);
        s(FSP_CMD_PAGE_PROGRAM, IGN);
        s(FSP_CMD_WRITE_ENABLE, ACC);
        @(posedge clk);
        chk(status_byte, 16'h0002);
        s(FSP_CMD_WRITE_DISABLE, ACC);
        @(posedge clk);
        chk(status_byte, 16'h0000);
        foreach (ops[i])
            run(1'b1, ops[i], 8'h00, 10'h000, 8'h00);
        run(1'b0, FSP_CMD_INTEGRITY_CHECK, 8'h00, 10'h000, 8'h00);
        run(1'b1, FSP_CMD_INTEGRITY_CHECK, 8'h00, 10'h000, 8'h02);
        s(FSP_CMD_WRITE_DISABLE, ACC);
        fsp_host_model_inst.we_then(FSP_CMD_CHIP_ERASE, 8'h00, 10'h000, ACC);
        fsp_host_model_inst.send(FSP_CMD_WRITE_ENABLE, 8'h00, 10'h000, IGN, 0);
        fsp_host_model_inst.send(FSP_CMD_READ_STATUS, 8'h00, 10'h000, ACC, 0);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        wait_abort();
        s(FSP_CMD_WRITE_ENABLE, IGN);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({ready_flag, status_byte}, 16'h0100);
        fsp_host_model_inst.we_then(FSP_CMD_PAGE_PROGRAM, 8'h00, 10'h000, ACC);
        fsp_host_model_inst.send(FSP_CMD_RESET_ENABLE, 8'h00, 10'h000, ACC, 0);
        fsp_host_model_inst.send(FSP_CMD_RESET, 8'h00, 10'h000, ACC, 0);
        wait_abort();
        @(posedge clk);
        chk({ready_flag, status_byte}, 16'h0100);
        s(FSP_CMD_RESET, IGN);
        s(FSP_CMD_RESET_ENABLE, ACC);
        s(FSP_CMD_READ_STATUS, ACC);
        s(FSP_CMD_RESET, IGN);
        s(FSP_CMD_SUSPEND, IGN);
        s(FSP_CMD_VCR_WRITE, ACC);
        s(FSP_CMD_NONVOLATILE_CONFIG_REG_WRITE, IGN);
        fsp_host_model_inst.we_then(FSP_CMD_PAGE_PROGRAM, 8'h00, 10'h000,
            ACC);
        s(FSP_CMD_SUSPEND, ACC);
        @(posedge clk);
        chk({ready_flag, status_byte}, 16'h0102);
        s(FSP_CMD_WRITE_DISABLE, IGN);
        s(FSP_CMD_RESUME, ACC);
        fsp_host_model_inst.poll_idle(ok);
        chk({ok, ready_flag, status_byte}, 16'h0300);
        repeat (3)
        begin
            rnd = 8'($random(seed));
            rnd[7] = 1'b0;
            run(1'b1, FSP_CMD_WRITE_STATUS, rnd, 10'h000, rnd & 8'h7C);
        end
        run(1'b1, FSP_CMD_WRITE_STATUS, 8'h04, 10'h000, 8'h04);
        fsp_host_model_inst.we_then(FSP_CMD_PAGE_PROGRAM, 8'h00, 10'h3FF, IGN);
        run(1'b1, FSP_CMD_PAGE_PROGRAM, 8'h00, 10'h3FE, 8'h04);
        protect_invert_bit <= 1'b1;
        fsp_host_model_inst.we_then(FSP_CMD_SECTOR_ERASE, 8'h00, 10'h3FE, IGN);
        run(1'b1, FSP_CMD_SECTOR_ERASE, 8'h00, 10'h3FF, 8'h04);
        protect_invert_bit <= 1'b0;
        run(1'b1, FSP_CMD_WRITE_STATUS, 8'h44, 10'h000, 8'h44);
        fsp_host_model_inst.we_then(FSP_CMD_PAGE_PROGRAM, 8'h00, 10'h000, IGN);
        run(1'b1, FSP_CMD_PAGE_PROGRAM, 8'h00, 10'h3FF, 8'h44);
        run(1'b1, FSP_CMD_WRITE_STATUS, 8'h80, 10'h000, 8'h80);
        write_protect_n <= 1'b0;
        repeat (3) @(posedge clk);
        fsp_host_model_inst.we_then(FSP_CMD_WRITE_STATUS, 8'h88, 10'h000, IGN);
        octal_double_rate_mode <= 1'b1;
        run(1'b1, FSP_CMD_WRITE_STATUS, 8'h88, 10'h000, 8'h88);
        octal_double_rate_mode <= 1'b0;
        write_protect_n <= 1'b1;
        repeat (3) @(posedge clk);
        run(1'b1, FSP_CMD_WRITE_STATUS, 8'h80, 10'h000, 8'h80);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        init_pulse(1'b1);
        chk({reset_output_pin_o, reset_output_pin_oe_n, ready_flag,
            status_byte}, 16'h0001);
        repeat (3) @(posedge clk);
        chk(16'(fsp_host_model_inst.exp_q.size()), 16'h0000);
        stop_test();
    end

    // whole run needs about 500 cycles; limit at 30000
    initial
    begin
        #750000;
        mismatches++;
        stop_test();
    end
endmodule

// *** inc/fsp_pkg.sv ***
// fsp_pkg: bit layout, reset values, commands and carriers of the flash
// status and protection register block.
// assumes one clock domain; command decoding is done upstream.
package fsp_pkg;

    // status byte bit positions
    localparam int FSP_BIT_BUSY = 0;
    localparam int FSP_BIT_WEL = 1;
    localparam int FSP_BIT_BP_LO = 2;
    localparam int FSP_BIT_BP_HI = 5;
    localparam int FSP_BIT_TB = 6;
    localparam int FSP_BIT_GUARD = 7;

    // factory defaults of the nonvolatile bits
    localparam logic [3:0] FSP_BP_RST = 4'h0;
    localparam logic FSP_TB_RST = 1'b0;
    localparam logic FSP_GUARD_RST = 1'b0;

    // array geometry in protection blocks
    localparam int FSP_BLK_W = 10;
    localparam logic [10:0] FSP_BLK_COUNT = 11'h400;
    localparam logic [3:0] FSP_BP_ALL = 4'hB;

    // default internal operation length in clock cycles
    localparam int FSP_OP_CYCLES = 16;

    typedef enum logic [4:0] {
        FSP_CMD_READ_STATUS,
        FSP_CMD_WRITE_ENABLE,
        FSP_CMD_WRITE_DISABLE,
        FSP_CMD_WRITE_STATUS,
        FSP_CMD_PAGE_PROGRAM,
        FSP_CMD_SECTOR_ERASE,
        FSP_CMD_BLOCK_ERASE,
        FSP_CMD_CHIP_ERASE,
        FSP_CMD_NONVOLATILE_CONFIG_REG_WRITE,
        FSP_CMD_VCR_WRITE,
        FSP_CMD_SECREG_PE,
        FSP_CMD_PATREG_PE,
        FSP_CMD_INTEGRITY_CHECK,
        FSP_CMD_SUSPEND,
        FSP_CMD_RESUME,
        FSP_CMD_RESET_ENABLE,
        FSP_CMD_RESET
    } fsp_cmd_t;

    typedef struct packed {
        fsp_cmd_t op;
        logic [7:0] wdata;
        logic [FSP_BLK_W-1:0] blk_lo;
        logic [FSP_BLK_W-1:0] blk_hi;
    } fsp_cmd_req_t;

endpackage

// *** logic/fsp_status_reg.sv ***
// fsp_status_reg: status byte, write enable latch, ready flag, block
// protection and status-write guard of a serial flash device.
// assumes an upstream decoder delivering one command per valid pulse and
// power-up logic reporting init result; write protect and reset pins async.
`timescale 1ns/10ps
module fsp_status_reg
    import fsp_pkg::*;
#(
    parameter int OP_CYCLES = fsp_pkg::FSP_OP_CYCLES
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins
    input wire logic write_protect_n,
    input wire logic reset_pin_n,
    output logic reset_output_pin_o,
    output logic reset_output_pin_oe_n,
    // power-up and mode
    input wire logic init_done,
    input wire logic init_fail,
    input wire logic octal_double_rate_mode,
    input wire logic protect_invert_bit,
    // commands
    input wire logic cmd_valid,
    input wire fsp_pkg::fsp_cmd_req_t cmd_req,
    output logic cmd_accepted,
    output logic cmd_ignored,
    // status
    output logic [7:0] status_byte,
    output logic ready_flag,
    output logic op_done,
    output logic op_abort
);
    import fsp_pkg::*;

    localparam int TW = $clog2(OP_CYCLES + 1);
    localparam logic [TW-1:0] T_LOAD = TW'(OP_CYCLES);
    localparam logic [TW-1:0] T_ONE = TW'(1);

    // elaboration-time refusal: a zero-length operation would never finish
    if (OP_CYCLES < 1)
        $error("OP_CYCLES must be at least 1");

    typedef enum logic [2:0] {
        ST_INIT, ST_FAIL, ST_IDLE, ST_BUSY, ST_SUSP
    } fsp_state_t;

    // protected-block hit for a target block range
    function automatic logic fsp_region_hit(
        input logic tb,
        input logic [3:0] bp,
        input logic inv,
        input logic [FSP_BLK_W-1:0] lo,
        input logic [FSP_BLK_W-1:0] hi
    );
        logic [10:0] n;
        logic [10:0] top_base;
        logic hit;
        n = 11'h000;
        if (bp >= FSP_BP_ALL)
            n = FSP_BLK_COUNT;
        else if (bp != 4'h0)
            n = 11'h001 << (bp - 4'h1);
        top_base = FSP_BLK_COUNT - n;
        unique case ({inv, tb})
            2'b00: hit = {1'b0, hi} >= top_base;
            2'b01: hit = {1'b0, lo} < n;
            2'b10: hit = {1'b0, lo} < top_base;
            default: hit = {1'b0, hi} >= n;
        endcase
        return hit;
    endfunction

    fsp_state_t state_r, state_nxt;
    logic wp_meta_r, wp_sync_r, rp_meta_r, rp_sync_r;
    logic wel_r, wel_saved_r, busy_r, rf_r, armed_r;
    logic [3:0] bp_r;
    logic tb_r, guard_r;
    logic [7:0] pend_r;
    fsp_cmd_t kind_r;
    logic [TW-1:0] timer_r;
    logic acc_r, ign_r, done_r, abort_r, oe_n_r;
    logic hit, guard_block, start, simple_ok, accept, sw_reset, hw_reset;
    logic abort, finish;

    // pins cross two flops before any use
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wp_meta_r <= 1'b1;
            wp_sync_r <= 1'b1;
            rp_meta_r <= 1'b1;
            rp_sync_r <= 1'b1;
        end
        else
        begin
            wp_meta_r <= write_protect_n;
            wp_sync_r <= wp_meta_r;
            rp_meta_r <= reset_pin_n;
            rp_sync_r <= rp_meta_r;
        end
    end

    always_comb
    begin
        hit = fsp_region_hit(tb_r, bp_r, protect_invert_bit,
                             cmd_req.blk_lo, cmd_req.blk_hi);
        // pin guard is meaningless on the octal double rate bus
        guard_block = guard_r && !wp_sync_r
                      && !octal_double_rate_mode;
        hw_reset = !rp_sync_r;
        start = 1'b0;
        simple_ok = 1'b0;
        if (state_r == ST_IDLE)
        begin
            unique case (cmd_req.op)
                FSP_CMD_PAGE_PROGRAM, FSP_CMD_SECTOR_ERASE,
                FSP_CMD_BLOCK_ERASE, FSP_CMD_CHIP_ERASE:
                    start = wel_r && !hit;
                FSP_CMD_WRITE_STATUS:
                    start = wel_r && !guard_block;
                FSP_CMD_NONVOLATILE_CONFIG_REG_WRITE, FSP_CMD_SECREG_PE, FSP_CMD_PATREG_PE:
                    start = wel_r;
                FSP_CMD_INTEGRITY_CHECK:
                    start = 1'b1;
                FSP_CMD_READ_STATUS, FSP_CMD_WRITE_ENABLE,
                FSP_CMD_WRITE_DISABLE, FSP_CMD_VCR_WRITE,
                FSP_CMD_RESET_ENABLE:
                    simple_ok = 1'b1;
                FSP_CMD_RESET:
                    simple_ok = armed_r;
                default:
                    simple_ok = 1'b0;
            endcase
        end
        else
        begin
            unique case (cmd_req.op)
                FSP_CMD_READ_STATUS:
                    simple_ok = 1'b1;
                FSP_CMD_SUSPEND:
                    simple_ok = state_r == ST_BUSY;
                FSP_CMD_RESUME:
                    simple_ok = state_r == ST_SUSP;
                FSP_CMD_RESET_ENABLE:
                    simple_ok = state_r != ST_INIT && state_r != ST_FAIL;
                FSP_CMD_RESET:
                    simple_ok = armed_r && state_r != ST_INIT
                                && state_r != ST_FAIL;
                default:
                    simple_ok = 1'b0;
            endcase
        end
        start = start && cmd_valid && !hw_reset;
        accept = cmd_valid && !hw_reset && (start || simple_ok);
        sw_reset = accept && cmd_req.op == FSP_CMD_RESET;
        abort = (sw_reset || hw_reset) && state_r != ST_INIT
                && state_r != ST_FAIL;
        finish = state_r == ST_BUSY && timer_r == T_ONE;
    end

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_INIT:
                if (init_done)
                    state_nxt = init_fail ? ST_FAIL : ST_IDLE;
            ST_FAIL:
                state_nxt = ST_FAIL;
            ST_IDLE:
                if (start)
                    state_nxt = ST_BUSY;
            ST_BUSY:
                if (finish)
                    state_nxt = ST_IDLE;
                else if (accept && cmd_req.op == FSP_CMD_SUSPEND)
                    state_nxt = ST_SUSP;
            ST_SUSP:
                if (accept && cmd_req.op == FSP_CMD_RESUME)
                    state_nxt = ST_BUSY;
        endcase
        if (abort)
            state_nxt = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= ST_INIT;
            busy_r <= 1'b1;
            rf_r <= 1'b0;
            oe_n_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            busy_r <= state_nxt != ST_IDLE && state_nxt != ST_SUSP;
            rf_r <= state_nxt == ST_IDLE || state_nxt == ST_SUSP;
            oe_n_r <= state_nxt != ST_INIT && state_nxt != ST_FAIL;
        end
    end

    // timer freezes while suspended
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            timer_r <= '0;
            kind_r <= FSP_CMD_READ_STATUS;
            pend_r <= 8'h00;
        end
        else if (start)
        begin
            timer_r <= T_LOAD;
            kind_r <= cmd_req.op;
            pend_r <= cmd_req.wdata;
        end
        else if (state_r == ST_BUSY && !abort)
            timer_r <= timer_r - T_ONE;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wel_r <= 1'b0;
            wel_saved_r <= 1'b0;
        end
        else if (abort || state_r == ST_INIT || state_r == ST_FAIL)
            wel_r <= 1'b0;
        else if (finish)
            wel_r <= kind_r == FSP_CMD_INTEGRITY_CHECK
                     ? wel_saved_r : 1'b0;
        else if (start && cmd_req.op == FSP_CMD_INTEGRITY_CHECK)
        begin
            wel_saved_r <= wel_r;
            wel_r <= 1'b1;
        end
        else if (accept && cmd_req.op == FSP_CMD_WRITE_ENABLE)
            wel_r <= 1'b1;
        else if (accept && cmd_req.op == FSP_CMD_WRITE_DISABLE)
            wel_r <= 1'b0;
    end

    // nonvolatile bits commit only when the write time has run out
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bp_r <= FSP_BP_RST;
            tb_r <= FSP_TB_RST;
            guard_r <= FSP_GUARD_RST;
        end
        else if (finish && !abort && kind_r == FSP_CMD_WRITE_STATUS)
        begin
            bp_r <= pend_r[FSP_BIT_BP_HI:FSP_BIT_BP_LO];
            tb_r <= pend_r[FSP_BIT_TB];
            guard_r <= pend_r[FSP_BIT_GUARD];
        end
    end

    // reset pair must be back to back
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            armed_r <= 1'b0;
        else if (cmd_valid)
            armed_r <= accept && cmd_req.op == FSP_CMD_RESET_ENABLE;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            acc_r <= 1'b0;
            ign_r <= 1'b0;
            done_r <= 1'b0;
            abort_r <= 1'b0;
        end
        else
        begin
            acc_r <= accept;
            ign_r <= cmd_valid && !accept;
            done_r <= finish && !abort;
            abort_r <= abort && (state_r == ST_BUSY || state_r == ST_SUSP);
        end
    end

    assign reset_output_pin_o = 1'b0;
    assign reset_output_pin_oe_n = oe_n_r;
    assign status_byte = {guard_r, tb_r, bp_r, wel_r, busy_r};
    assign ready_flag = rf_r;
    assign cmd_accepted = acc_r;
    assign cmd_ignored = ign_r;
    assign op_done = done_r;
    assign op_abort = abort_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_busy_flags: assert property (state_r == ST_BUSY |->
        busy_r && wel_r && !rf_r) else $error("busy flags wrong");
    a_busy_ignore: assert property (cmd_valid && state_r == ST_BUSY
        && cmd_req.op == FSP_CMD_WRITE_ENABLE |=> ign_r && !acc_r)
        else $error("command taken while busy");
    a_reset_abort: assert property (sw_reset && state_r == ST_BUSY |=>
        abort_r && state_r == ST_IDLE && !wel_r)
        else $error("reset did not abort");
    a_done_ready: assert property (done_r |-> !busy_r && rf_r)
        else $error("ready not set at end");
    a_check_restore: assert property (finish && !abort
        && kind_r == FSP_CMD_INTEGRITY_CHECK |=> wel_r == $past(wel_saved_r))
        else $error("latch not restored");
    a_init_fail: assert property (state_r == ST_FAIL |->
        busy_r && !wel_r && !rf_r && !reset_output_pin_oe_n)
        else $error("fail signature wrong");
    a_init_ok: assert property (state_r == ST_INIT && init_done
        && !init_fail |=> !busy_r && !wel_r && rf_r
        && reset_output_pin_oe_n) else $error("good power-up");
    a_wel_set: assert property (cmd_valid && state_r == ST_IDLE
        && !hw_reset && cmd_req.op == FSP_CMD_WRITE_ENABLE |=> wel_r)
        else $error("latch not set");
    a_nowel_refuse: assert property (cmd_valid && state_r == ST_IDLE
        && !wel_r && cmd_req.op == FSP_CMD_PAGE_PROGRAM |=>
        ign_r && !busy_r) else $error("program without latch");
    a_wel_clear: assert property (done_r && kind_r !=
        FSP_CMD_INTEGRITY_CHECK |-> !wel_r)
        else $error("latch kept after write");
    a_nv_change: assert property ($changed(status_byte[7:2]) |->
        done_r && kind_r == FSP_CMD_WRITE_STATUS)
        else $error("protect bits moved");
    a_guard_block: assert property (cmd_valid && state_r == ST_IDLE
        && cmd_req.op == FSP_CMD_WRITE_STATUS && guard_r && !wp_sync_r
        && !octal_double_rate_mode |=> ign_r)
        else $error("guarded write taken");
    a_prot_ignore: assert property (cmd_valid && state_r == ST_IDLE
        && cmd_req.op == FSP_CMD_SECTOR_ERASE && hit |=> ign_r
        && !busy_r) else $error("protected erase taken");

    c_program: cover property (start && cmd_req.op ==
        FSP_CMD_PAGE_PROGRAM ##[1:64] done_r);
    c_check: cover property (start && cmd_req.op ==
        FSP_CMD_INTEGRITY_CHECK ##[1:64] done_r);
    c_guard: cover property (cmd_valid && guard_block
        && cmd_req.op == FSP_CMD_WRITE_STATUS);
    c_fail: cover property (state_r == ST_FAIL);

endmodule
